/* File: dv/rx_event_regs_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module rx_event_regs_properties (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        irq,
	input wire logic        vid_hsync,
	input wire logic        vid_vsync,
	input wire logic [7:0]  avs_address,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic [31:0] cause_events
);
	logic [7:0] hw_r, hc_r;
	// shadow of the pulse-width field, counted against the pulse
	always_ff @(posedge clk or negedge nrst)
		if (!nrst) begin
			hw_r <= 8'h0F;
			hc_r <= 8'h00;
		end else begin
			if (avs_write && !avs_waitrequest && avs_address == 8'h50) hw_r <= avs_writedata[7:0];
			hc_r <= vid_hsync ? hc_r + 8'h01 : 8'h00;
		end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_ANSWER: assert property ($rose(avs_read | avs_write) |-> ##[1:3] !avs_waitrequest)
		else $error("no answer");
	AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	AST_UNUSED: assert property (!avs_waitrequest && avs_read && avs_address == 8'h48 |-> (avs_readdata & 32'h0FFC0028) == 32'h0)
		else $error("unused cause bit set");
	AST_UNMAP: assert property (!avs_waitrequest && avs_read && avs_address == 8'h00 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	AST_HWIDTH: assert property ($fell(vid_hsync) |-> hc_r == hw_r)
		else $error("hsync width wrong");
	AST_VMIN: assert property ($rose(vid_vsync) |-> vid_vsync [*8])
		else $error("vsync too short");
	AST_CLR: assert property (avs_waitrequest && avs_write && avs_address == 8'h48 && cause_events == 32'h0 ##1 !avs_waitrequest && cause_events == 32'h0 |=> !irq)
		else $error("cause not cleared");
	AST_RD_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	COV_HS: cover property ($fell(vid_hsync));
	COV_IRQ: cover property ($rose(irq));
	COV_CAUSE: cover property (!avs_waitrequest && avs_read && avs_address == 8'h48);
endmodule // rx_event_regs_properties
bind rx_event_regs rx_event_regs_properties rx_event_regs_properties_inst (.*);
`default_nettype wire

/* File: dv/rx_event_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module rx_event_regs_tb;
	logic        clk, nrst, avs_read, avs_write, avs_waitrequest, irq, vid_hsync, vid_vsync, i2c_div_valid;
	logic [7:0]  avs_address, i2c_div_out;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, cause_events;
	logic [15:0] hs_w, vs_w;
	int          err_total, n_tests, cyc;
	rx_event_regs #(.LINES_PER_FRAME(16'd4)) rx_event_regs_inst (.*);
	sync_sink sync_sink_inst (.*);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task close_out;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			close_out;
		end
	end
	task chk(input [31:0] g, input [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task acc(input rw, input [7:0] a, input [31:0] v);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= v;
		if (rw) avs_write <= 1'b1;
		else avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		if (!rw) chk(avs_readdata, v);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task ev(input [31:0] v);
		@(posedge clk);
		cause_events <= v;
		@(posedge clk);
		cause_events <= 32'h0;
	endtask
	initial begin
		{nrst, avs_read, avs_write, avs_address, avs_writedata, cause_events} = 0;
		avs_byteenable = 4'hF;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		acc(0, 8'h50, 32'h0F0F);
		acc(0, 8'h58, 32'h3F);
		acc(0, 8'h44, 32'hFFFFFFFF);
		acc(0, 8'h48, 32'h0);
		$display("reset test done");
		ev(32'hFFFFFFFF);
		acc(0, 8'h48, 32'hF003FFD7);
		chk({31'h0, irq}, 32'h0);
		acc(0, 8'h48, 32'h0);
		acc(1, 8'h44, 32'h0);
		ev(32'h10);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		acc(1, 8'h48, 32'h5A);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		acc(0, 8'h48, 32'h0);
		$display("cause test done");
		acc(1, 8'h70, 32'h00040020);
		acc(1, 8'h50, 32'h0305);
		acc(1, 8'h58, 32'h40);
		repeat (600) @(posedge clk);
		chk({16'h0, hs_w}, 32'h5);
		chk({16'h0, vs_w}, 32'h40);
		acc(1, 8'h60, 32'h0C);
		acc(1, 8'h70, 32'h80040020);
		repeat (2) @(posedge clk);
		chk({24'h0, i2c_div_out}, 32'h0C);
		chk({31'h0, i2c_div_valid}, 32'h1);
		acc(0, 8'h00, 32'h0);
		$display("timing test done");
		close_out;
	end
endmodule // rx_event_regs_tb
`default_nettype wire

/* File: dv/sync_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module sync_sink (
	input wire logic         clk,
	input wire logic         nrst,
	input wire logic         vid_hsync,
	input wire logic         vid_vsync,
	output logic      [15:0] hs_w,
	output logic      [15:0] vs_w
);
	logic [15:0] hc, vc;
	// latches the width of each finished pulse
	always @(posedge clk or negedge nrst)
		if (!nrst) begin
			{hc, vc, hs_w, vs_w} <= 64'h0;
		end else begin
			hc <= vid_hsync ? hc + 16'h0001 : 16'h0000;
			vc <= vid_vsync ? vc + 16'h0001 : 16'h0000;
			if (hc != 16'h0000 && !vid_hsync) hs_w <= hc;
			if (vc != 16'h0000 && !vid_vsync) vs_w <= vc;
		end
endmodule // sync_sink
`default_nettype wire

/* File: src/rx_event_consts.vh */
`ifndef RX_EVENT_CONSTS_VH
`define RX_EVENT_CONSTS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_CAUSE        8'h48
`define OFS_MASK         8'h44
`define OFS_HSYNC        8'h50
`define OFS_VSYNC        8'h58
`define OFS_I2C_DIV      8'h60
`define OFS_TIMING_CTRL  8'h70
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_HSYNC        16'h0F0F
`define RST_VSYNC        16'h003F
`define RST_MASK         32'hFFFFFFFF
`define RST_I2C_DIV      8'h00
`define RST_LINE_ACTIVE  16'h0780
`define RST_LINE_GAP     16'h0040
// ----------------------------------------
// field positions
// ----------------------------------------
`define HS_WIDTH_LSB     0
`define HS_GAP_LSB       8
`define CAUSE_USED       32'hF003FFD7
`define CTRL_REV14_BIT   31
`endif

/* File: src/rx_event_regs.v */
`timescale 1ns/10ps
`default_nettype none
`include "rx_event_consts.vh"

module rx_event_regs #(
	parameter LINES_PER_FRAME = 16'd1125
) (
	input  wire        clk,
	input  wire        nrst,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire [31:0] cause_events,
	output reg         irq,
	output reg         vid_hsync,
	output reg         vid_vsync,
	output reg  [7:0]  i2c_div_out,
	output reg         i2c_div_valid
);

// ----------------------------------------
// registers
// ----------------------------------------
reg  [31:0] cause_r;
reg  [31:0] mask_r;
reg  [15:0] hsync_r;
reg  [15:0] vsync_r;
reg  [7:0]  i2c_div_r;
reg  [31:0] ctrl_r;
reg         done_r;
wire        req;
wire        rd_cause;
wire        wr_cause;
wire [31:0] be_mask;
reg  [31:0] rdata;

assign req      = (avs_read | avs_write) & ~done_r;
assign rd_cause = req & avs_read & (avs_address == `OFS_CAUSE);
assign wr_cause = req & avs_write & (avs_address == `OFS_CAUSE);
assign be_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

// ----------------------------------------
// bus slave: one wait state, answer on second edge
// ----------------------------------------
// done_r blocks a second take while the master still holds the request
// after the answer, so every access costs at least one idle cycle
// read data stands until the next read is taken
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		done_r          <= 1'b0;
		avs_waitrequest <= 1'b1;
		avs_readdata    <= 32'h00000000;
	end else begin
		done_r          <= req;
		avs_waitrequest <= ~req;
		if (req && avs_read)
			avs_readdata <= rdata;
	end
end

// read mux; the registered copy is what the bus sees
always @* begin
	case (avs_address)
		`OFS_CAUSE:       rdata = cause_r & `CAUSE_USED;
		`OFS_MASK:        rdata = mask_r;
		`OFS_HSYNC:       rdata = {16'h0000, hsync_r};
		`OFS_VSYNC:       rdata = {16'h0000, vsync_r};
		`OFS_I2C_DIV:     rdata = {24'h000000, i2c_div_r};
		`OFS_TIMING_CTRL: rdata = ctrl_r;
		default:          rdata = 32'h00000000;
	endcase
end

// ----------------------------------------
// writable registers
// ----------------------------------------
// byte lanes are merged so a partial write keeps the other bytes
// the cause register has no write path here: a write only clears it
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		mask_r    <= `RST_MASK;
		hsync_r   <= `RST_HSYNC;
		vsync_r   <= `RST_VSYNC;
		i2c_div_r <= `RST_I2C_DIV;
		ctrl_r    <= {`RST_LINE_GAP, `RST_LINE_ACTIVE};
	end else if (req && avs_write) begin
		case (avs_address)
			`OFS_MASK:        mask_r    <= (mask_r & ~be_mask) | (avs_writedata & be_mask);
			`OFS_HSYNC:       hsync_r   <= (hsync_r & ~be_mask[15:0]) |
				(avs_writedata[15:0] & be_mask[15:0]);
			`OFS_VSYNC:       vsync_r   <= (vsync_r & ~be_mask[15:0]) |
				(avs_writedata[15:0] & be_mask[15:0]);
			`OFS_I2C_DIV:     if (avs_byteenable[0]) i2c_div_r <= avs_writedata[7:0];
			`OFS_TIMING_CTRL: ctrl_r    <= (ctrl_r & ~be_mask) | (avs_writedata & be_mask);
			default:          ;
		endcase
	end
end

// ----------------------------------------
// cause register
// ----------------------------------------
// one sticky flip-flop per cause bit; unused positions stay zero
// whatever the event inputs do, so they always read back as zero
// an event in the clearing cycle survives: set wins over clear
// the clear strobe comes from the take edge of a cause access
localparam [31:0] CAUSE_MAP = `CAUSE_USED;

wire        cause_clr;

assign cause_clr = rd_cause | wr_cause;

// reserved positions are still flip-flops so the vector reads uniformly
genvar gi;
generate
	for (gi = 0; gi < 32; gi = gi + 1) begin : g_cause
		if (CAUSE_MAP[gi]) begin : g_used
			always @(posedge clk or negedge nrst) begin
				if (!nrst)
					cause_r[gi] <= 1'b0;
				else if (cause_events[gi])
					cause_r[gi] <= 1'b1;
				else if (cause_clr)
					cause_r[gi] <= 1'b0;
			end
		end else begin : g_unused
			// no event can reach a reserved position
			always @(posedge clk or negedge nrst) begin
				if (!nrst)
					cause_r[gi] <= 1'b0;
				else
					cause_r[gi] <= 1'b0;
			end
		end
	end
endgenerate

// ----------------------------------------
// interrupt
// ----------------------------------------
// one cycle behind the cause bits; a mask bit of one hides its cause
// registered so the pin never glitches while causes change
// a level, not a pulse, until software reads or writes the cause register
wire [31:0] cause_live;

assign cause_live = cause_r & ~mask_r;

always @(posedge clk or negedge nrst) begin
	if (!nrst)
		irq <= 1'b0;
	else
		irq <= |cause_live;
end

// ----------------------------------------
// fast serial divider hand-off
// ----------------------------------------
// control bit 31 selects revision 1.4 operation; below it the divider
// is still copied out but flagged unusable
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		i2c_div_out   <= 8'h00;
		i2c_div_valid <= 1'b0;
	end else begin
		i2c_div_out   <= i2c_div_r;
		i2c_div_valid <= ctrl_r[`CTRL_REV14_BIT];
	end
end

// ----------------------------------------
// timing generator
// ----------------------------------------
// line: active pixels, front gap, sync pulse, back gap
// the back gap field stops at bit 30: bit 31 is the revision select
// each state runs on cnt_r, which restarts at every state change
localparam ST_ACTIVE = 2'd0;
localparam ST_FRONT  = 2'd1;
localparam ST_PULSE  = 2'd2;
localparam ST_BACK   = 2'd3;

reg  [1:0]  state_r;
reg  [15:0] cnt_r;
reg  [15:0] line_r;
reg  [15:0] vcnt_r;
wire [15:0] cnt_inc;
wire [15:0] act_len;
wire [15:0] front_len;
wire [15:0] pulse_len;
wire [15:0] back_len;
wire        line_end;
wire        frame_end;

assign cnt_inc   = cnt_r + 16'd1;
assign act_len   = ctrl_r[15:0];
assign front_len = {8'h00, hsync_r[15:8]};
assign pulse_len = {8'h00, hsync_r[7:0]};
assign back_len  = {1'b0, ctrl_r[30:16]};
// a line ends with its back gap; a frame ends with its last line
assign line_end  = (state_r == ST_BACK) && (cnt_inc >= back_len);
assign frame_end = line_end && (line_r + 16'd1 >= LINES_PER_FRAME);

// fields are read live, so a width written mid-pulse bends that pulse
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		state_r   <= ST_ACTIVE;
		cnt_r     <= 16'h0000;
		line_r    <= 16'h0000;
		vid_hsync <= 1'b0;
	end else begin
		case (state_r)
			ST_ACTIVE: begin
				if (cnt_inc >= act_len) begin
					cnt_r <= 16'h0000;
					if (front_len == 16'h0000) begin
						state_r   <= ST_PULSE;
						vid_hsync <= (pulse_len != 16'h0000);
					end else begin
						state_r <= ST_FRONT;
					end
				end else begin
					cnt_r <= cnt_inc;
				end
			end
			ST_FRONT: begin
				if (cnt_inc >= front_len) begin
					cnt_r     <= 16'h0000;
					state_r   <= ST_PULSE;
					vid_hsync <= (pulse_len != 16'h0000);
				end else begin
					cnt_r <= cnt_inc;
				end
			end
			ST_PULSE: begin
				if (cnt_inc >= pulse_len) begin
					cnt_r     <= 16'h0000;
					state_r   <= ST_BACK;
					vid_hsync <= 1'b0;
				end else begin
					cnt_r <= cnt_inc;
				end
			end
			ST_BACK: begin
				if (line_end) begin
					cnt_r   <= 16'h0000;
					state_r <= ST_ACTIVE;
					line_r  <= frame_end ? 16'h0000 : line_r + 16'd1;
				end else begin
					cnt_r <= cnt_inc;
				end
			end
			default: begin
				cnt_r   <= 16'h0000;
				state_r <= ST_ACTIVE;
			end
		endcase
	end
end

// ----------------------------------------
// vertical sync
// ----------------------------------------
// pulse counted in clocks from frame end, independent of line timing
// a new frame end while a pulse runs restarts the count
// a zero length gives no pulse at all
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		vcnt_r    <= 16'h0000;
		vid_vsync <= 1'b0;
	end else if (frame_end) begin
		vcnt_r    <= vsync_r;
		vid_vsync <= (vsync_r != 16'h0000);
	end else if (vcnt_r > 16'd1) begin
		vcnt_r <= vcnt_r - 16'd1;
	end else begin
		vcnt_r    <= 16'h0000;
		vid_vsync <= 1'b0;
	end
end

endmodule // rx_event_regs
`default_nettype wire
